// File: design/isb_pkg.sv
// Purpose: constants and types for the independent LED sink blink controller
// Assumes: 25 MHz pclk, APB register access with 32-bit data
// Notes:   register index times four gives the APB byte address
package isb_pkg;

	// ==========================================================
	// register map
	localparam logic [7:0] IDX_LAW    = 8'h1a;
	localparam logic [7:0] IDX_ENABLE = 8'h1b;
	localparam logic [7:0] IDX_TIME1  = 8'h1c;
	localparam logic [7:0] IDX_STATUS = 8'h20;
	localparam logic [7:0] ADDR_LAW    = {IDX_LAW[5:0], 2'b00};
	localparam logic [7:0] ADDR_ENABLE = {IDX_ENABLE[5:0], 2'b00};
	localparam logic [7:0] ADDR_TIME1  = {IDX_TIME1[5:0], 2'b00};
	localparam logic [7:0] ADDR_STATUS = {IDX_STATUS[5:0], 2'b00};

	// ==========================================================
	// reset values and field positions
	localparam logic [1:0] RST_LAW    = 2'h0;
	localparam logic [6:0] RST_ENABLE = 7'h00;
	localparam logic [7:0] RST_TIME1  = 8'h00;
	localparam int         ON_LSB     = 6;
	localparam int         LED7_LSB   = 4;
	localparam int         LED6_LSB   = 2;
	localparam int         LED5_LSB   = 0;
	localparam int         NUM_SINKS  = 7;

	// ==========================================================
	// timing: one prescaler tick is 100 ms
	localparam int CLK_KHZ      = 25000;
	localparam int TICK_MS      = 100;
	localparam int TICK_CYCLES  = TICK_MS * CLK_KHZ;
	localparam int ON_MS_0      = 200;
	localparam int ON_MS_1      = 600;
	localparam int ON_MS_2      = 800;
	localparam int ON_MS_3      = 1200;
	localparam int OFF_MS_1     = 600;
	localparam int OFF_MS_2     = 1200;
	localparam int OFF_MS_3     = 1800;
	localparam logic [4:0] ON_TICKS_0  = 5'(ON_MS_0 / TICK_MS);
	localparam logic [4:0] ON_TICKS_1  = 5'(ON_MS_1 / TICK_MS);
	localparam logic [4:0] ON_TICKS_2  = 5'(ON_MS_2 / TICK_MS);
	localparam logic [4:0] ON_TICKS_3  = 5'(ON_MS_3 / TICK_MS);
	localparam logic [4:0] OFF_TICKS_1 = 5'(OFF_MS_1 / TICK_MS);
	localparam logic [4:0] OFF_TICKS_2 = 5'(OFF_MS_2 / TICK_MS);
	localparam logic [4:0] OFF_TICKS_3 = 5'(OFF_MS_3 / TICK_MS);

	// ==========================================================
	// fade law encodings and sink states
	typedef enum logic [1:0] {
		LAW_LIN_A   = 2'h0,
		LAW_LIN_B   = 2'h1,
		LAW_CUBIC_A = 2'h2,
		LAW_CUBIC_B = 2'h3
	} isb_law_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ON   = 2'b01,
		ST_OFF  = 2'b11
	} isb_state_t;

endpackage

// File: design/isb_top.sv
// Purpose: APB register block and blink sequencer for seven LED current sinks
// Assumes: single pclk domain, zero-wait APB slave
// Notes:   LED1..LED4 have no off-time field here and run continuously when enabled
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
module isb_top
	import isb_pkg::*;
#(
	parameter int TICK_LEN = TICK_CYCLES
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// sink controls
	output logic      [6:0]  per_led_sink_on,
	output logic      [1:0]  fade_transfer_law,
	output logic             fade_cubic
);

	// ==========================================================
	// apb decode
	logic        setup;
	logic        wr;
	logic        hit;
	logic [31:0] rdata;
	logic [1:0]  law_q, law_d;
	logic [6:0]  en_q, en_d;
	logic [7:0]  time_q, time_d;
	logic [31:0] prdata_q, prdata_d;
	logic        err_q, err_d;
	logic [6:0]  on_q, on_d;

	assign setup  = psel & ~penable;
	assign wr     = psel & penable & pwrite & ~err_q;
	assign pready = psel & penable;
	assign prdata = prdata_q;
	assign pslverr = pready & err_q;

	// read mux, sampled in the setup cycle
	always_comb begin
		hit   = 1'b1;
		rdata = 32'h0;
		case (paddr)
			ADDR_LAW:    rdata = {30'h0, law_q};
			ADDR_ENABLE: rdata = {25'h0, en_q};
			ADDR_TIME1:  rdata = {24'h0, time_q};
			ADDR_STATUS: rdata = {25'h0, on_q};
			default:     hit = 1'b0;
		endcase
	end

	// register next values
	always_comb begin
		law_d    = law_q;
		en_d     = en_q;
		time_d   = time_q;
		prdata_d = prdata_q;
		err_d    = err_q;
		if (setup) begin
			prdata_d = pwrite ? 32'h0 : rdata;
			err_d    = ~hit | (pwrite & (paddr == ADDR_STATUS));
		end
		if (wr) begin
			case (paddr)
				ADDR_LAW:    law_d = pwdata[1:0];
				ADDR_ENABLE: en_d = pwdata[6:0];
				ADDR_TIME1:  time_d = pwdata[7:0];
				default:     law_d = law_q;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			law_q    <= RST_LAW;
			en_q     <= RST_ENABLE;
			time_q   <= RST_TIME1;
			prdata_q <= 32'h0;
			err_q    <= 1'b0;
		end else begin
			law_q    <= law_d;
			en_q     <= en_d;
			time_q   <= time_d;
			prdata_q <= prdata_d;
			err_q    <= err_d;
		end
	end

	// fade law goes straight to the fade engine; cubic flag picks the nonlinear steps
	assign fade_transfer_law = law_q;
	assign fade_cubic        = law_q[1];

	// ==========================================================
	// shared tick prescaler
	logic [21:0] presc_q, presc_d;
	logic        tick;
	logic [6:0]  start;
	logic [4:0]  on_ticks;

	assign start = en_d & ~en_q;
	assign tick  = (presc_q == 22'(TICK_LEN - 1));

	// restart the prescaler when a write starts new sinks, so their phases line up
	always_comb begin
		if (|start || tick) begin
			presc_d = 22'h0;
		end else begin
			presc_d = presc_q + 22'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			presc_q <= 22'h0;
		end else begin
			presc_q <= presc_d;
		end
	end

	// one on time decoded for all sinks
	always_comb begin
		case (time_q[ON_LSB +: 2])
			2'h0:    on_ticks = ON_TICKS_0;
			2'h1:    on_ticks = ON_TICKS_1;
			2'h2:    on_ticks = ON_TICKS_2;
			default: on_ticks = ON_TICKS_3;
		endcase
	end

	// ==========================================================
	// per-sink sequencers
	isb_state_t st_q [NUM_SINKS];
	isb_state_t st_d [NUM_SINKS];
	logic [4:0] cnt_q [NUM_SINKS];
	logic [4:0] cnt_d [NUM_SINKS];
	logic [1:0] off_code [NUM_SINKS];
	logic [4:0] off_ticks [NUM_SINKS];

	assign off_code[0] = 2'h0;
	assign off_code[1] = 2'h0;
	assign off_code[2] = 2'h0;
	assign off_code[3] = 2'h0;
	assign off_code[4] = time_q[LED5_LSB +: 2];
	assign off_code[5] = time_q[LED6_LSB +: 2];
	assign off_code[6] = time_q[LED7_LSB +: 2];

	genvar gi;
	generate
		for (gi = 0; gi < NUM_SINKS; gi++) begin : g_sink
			// off period from this sink's own field; LED1..LED4 have none and decode zero
			always_comb begin
				case (off_code[gi])
					2'h1:    off_ticks[gi] = OFF_TICKS_1;
					2'h2:    off_ticks[gi] = OFF_TICKS_2;
					2'h3:    off_ticks[gi] = OFF_TICKS_3;
					default: off_ticks[gi] = 5'h0;
				endcase
			end

			// on/off sequence
			always_comb begin
				st_d[gi]  = st_q[gi];
				cnt_d[gi] = cnt_q[gi];
				if (!en_d[gi]) begin
					st_d[gi]  = ST_IDLE;
					cnt_d[gi] = 5'h0;
				end else if (start[gi]) begin
					st_d[gi]  = ST_ON;
					cnt_d[gi] = 5'h0;
				end else begin
					case (st_q[gi])
						ST_ON: begin
							if (off_code[gi] != 2'h0 && tick) begin
								if (cnt_q[gi] == on_ticks - 5'h1) begin
									st_d[gi]  = ST_OFF;
									cnt_d[gi] = 5'h0;
								end else begin
									cnt_d[gi] = cnt_q[gi] + 5'h1;
								end
							end
						end
						ST_OFF: begin
							if (off_code[gi] == 2'h0) begin
								st_d[gi]  = ST_ON;
								cnt_d[gi] = 5'h0;
							end else if (tick) begin
								if (cnt_q[gi] == off_ticks[gi] - 5'h1) begin
									st_d[gi]  = ST_ON;
									cnt_d[gi] = 5'h0;
								end else begin
									cnt_d[gi] = cnt_q[gi] + 5'h1;
								end
							end
						end
						default: begin
							st_d[gi]  = ST_ON;
							cnt_d[gi] = 5'h0;
						end
					endcase
				end
				on_d[gi] = (st_d[gi] == ST_ON);
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					st_q[gi]  <= ST_IDLE;
					cnt_q[gi] <= 5'h0;
					on_q[gi]  <= 1'b0;
				end else begin
					st_q[gi]  <= st_d[gi];
					cnt_q[gi] <= cnt_d[gi];
					on_q[gi]  <= on_d[gi];
				end
			end

			// on phase ends only after the shared on time
			chk_on_period_len: assert property (@(posedge pclk) disable iff (!presetn)
				(st_q[gi] == ST_ON && st_d[gi] == ST_OFF) |-> (tick && cnt_q[gi] == on_ticks - 5'h1))
				else $error("on phase ended early");

			// off phase ends after own off time or when blinking stops
			chk_off_period_len: assert property (@(posedge pclk) disable iff (!presetn)
				(st_q[gi] == ST_OFF && st_d[gi] == ST_ON && !start[gi] && off_code[gi] != 2'h0)
				|-> (tick && cnt_q[gi] == off_ticks[gi] - 5'h1))
				else $error("off phase ended early");

			// disabled sink is dark on the next edge
			chk_disable_dark: assert property (@(posedge pclk) disable iff (!presetn)
				!en_d[gi] |=> !per_led_sink_on[gi])
				else $error("disabled sink still on");

			// a lit sink with no off time stays lit while it remains enabled
			chk_steady_sink: assert property (@(posedge pclk) disable iff (!presetn)
				(en_q[gi] && en_d[gi] && off_code[gi] == 2'h0 && st_q[gi] == ST_ON) |=> per_led_sink_on[gi])
				else $error("continuous sink went dark");
		end
	endgenerate

	assign per_led_sink_on = on_q;

	// ==========================================================
	// checks
	// law write reaches the fade engine outputs one edge later
	chk_law_write_out: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && paddr == ADDR_LAW) |=> (fade_transfer_law == $past(pwdata[1:0]) && fade_cubic == $past(pwdata[1])))
		else $error("fade law not taken from write");

	// newly enabled sinks light at once, cleared bits go dark at once
	chk_enable_start: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && paddr == ADDR_ENABLE) |=>
		((per_led_sink_on & $past(pwdata[6:0]) & ~$past(en_q)) == ($past(pwdata[6:0]) & ~$past(en_q)))
		&& ((per_led_sink_on & ~$past(pwdata[6:0])) == 7'h0))
		else $error("enable write did not act");

	// led7 with off time disabled keeps conducting
	chk_steady_on: assert property (@(posedge pclk) disable iff (!presetn)
		(en_q[6] && time_q[LED7_LSB +: 2] == 2'h0 && per_led_sink_on[6] && !(wr && paddr != ADDR_LAW))
		|=> per_led_sink_on[6])
		else $error("continuous sink blinked");

	// led6 output follows its off phase
	chk_off_phase_dark: assert property (@(posedge pclk) disable iff (!presetn)
		(st_q[5] == ST_OFF) |-> !per_led_sink_on[5] ##1 (st_q[5] != ST_OFF || !per_led_sink_on[5]))
		else $error("sink lit during off phase");

	// sinks started by one write light together on a fresh prescaler phase
	chk_sync_launch: assert property (@(posedge pclk) disable iff (!presetn)
		(|start) |=> (presc_q == 22'h0 && (per_led_sink_on & $past(start)) == $past(start)))
		else $error("new sinks not started together");

	// refused writes leave every register untouched
	chk_bad_write_ignored: assert property (@(posedge pclk) disable iff (!presetn)
		(pslverr && pwrite) |=> ($stable(law_q) && $stable(en_q) && $stable(time_q)))
		else $error("refused write changed a register");

	// prescaler never runs past one tick length
	chk_presc_range: assert property (@(posedge pclk) disable iff (!presetn)
		presc_q <= 22'(TICK_LEN - 1))
		else $error("prescaler out of range");

	// refused reads return zero data
	chk_err_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
		(pslverr && !pwrite) |-> (prdata == 32'h0))
		else $error("refused read returned data");

	// main scenarios seen
	cov_blink_cycle: cover property (@(posedge pclk) disable iff (!presetn)
		st_q[6] == ST_OFF ##1 st_q[6] == ST_ON);
	cov_multi_start: cover property (@(posedge pclk) disable iff (!presetn)
		$countones(start) > 1);
	cov_cubic_law: cover property (@(posedge pclk) disable iff (!presetn)
		fade_transfer_law == LAW_CUBIC_B);
	cov_bad_addr: cover property (@(posedge pclk) disable iff (!presetn)
		pslverr);
	cov_steady_led6: cover property (@(posedge pclk) disable iff (!presetn)
		en_q[5] && time_q[LED6_LSB +: 2] == 2'h0 && per_led_sink_on[5]);

endmodule // isb_top

// File: verification/isb_tb.sv
// ==========================================================
// Purpose: self-checking bench for the LED sink blink controller
// Assumes: 25 MHz pclk, zero-wait APB slave, shortened tick of TL cycles
// Notes:   expected sink levels are worked out here from the timing codes
`timescale 1ns/1ps
module testbench import isb_pkg::*;;
	localparam int TL    = 10;
	localparam int LIMIT = 20000;
	// ==========================================================
	// design signals and bench state
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [6:0]  per_led_sink_on;
	logic [1:0]  fade_transfer_law;
	logic        fade_cubic;
	int          fails;
	int          n_tests;
	int          cyc = 0;
	logic [31:0] rd;
	logic        err;

	isb_top #(.TICK_LEN(TL)) dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.per_led_sink_on(per_led_sink_on), .fade_transfer_law(fade_transfer_law),
		.fade_cubic(fade_cubic)
	);

	// ==========================================================
	// clock and hang guard
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			fails = fails + 1;
			end_sim();
		end
	end

	// ==========================================================
	// shared helpers
	task automatic end_sim();
		$display("tests=%0d fails=%0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// one apb transfer; read data and error taken at the edge pready is seen
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// expected sink levels k cycles after the enabling write edge
	function automatic logic [6:0] exp_on(input logic [7:0] t1, input logic [6:0] en, input int k);
		int         on_t[4]  = '{2, 6, 8, 12};
		int         off_t[4] = '{0, 6, 12, 18};
		logic [6:0] r;
		int         o;
		int         per;
		r = en;
		for (int i = 4; i < 7; i++) begin
			o = off_t[t1[2*(i-4) +: 2]];
			per = (on_t[t1[7:6]] + o) * TL;
			if (o != 0 && en[i] && (k % per) >= on_t[t1[7:6]] * TL) r[i] = 1'b0;
		end
		return r;
	endfunction

	// ==========================================================
	// scenarios
	task automatic t_reset();
		apb(1'b0, ADDR_LAW, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, ADDR_ENABLE, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, ADDR_TIME1, 32'h0);
		chk(rd, 32'h0);
		chk({25'h0, per_led_sink_on}, 32'h0);
	endtask

	// every law code, reserved upper bits written as ones
	task automatic t_law();
		for (int c = 0; c < 4; c++) begin
			apb(1'b1, ADDR_LAW, 32'hffff_fffc | c);
			#1;
			chk({30'h0, fade_transfer_law}, c);
			chk({31'h0, fade_cubic}, (c >> 1));
			apb(1'b0, ADDR_LAW, 32'h0);
			chk(rd, c);
		end
	endtask

	// reserved enable bit, read-only status, unmapped place
	task automatic t_regs();
		apb(1'b1, ADDR_ENABLE, 32'h0000_00ff);
		#1;
		chk({25'h0, per_led_sink_on}, 32'h7f);
		apb(1'b0, ADDR_ENABLE, 32'h0);
		chk(rd, 32'h7f);
		apb(1'b1, ADDR_STATUS, 32'h0);
		chk({31'h0, err}, 32'h1);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(rd, 32'h7f);
		apb(1'b0, 8'h04, 32'h0);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0);
		apb(1'b1, ADDR_ENABLE, 32'h0);
		#1;
		chk({25'h0, per_led_sink_on}, 32'h0);
	endtask

	// program times, enable in one write, follow every cycle, then disable
	task automatic t_blink(input logic [7:0] t1, input logic [6:0] en, input int ncyc);
		apb(1'b1, ADDR_TIME1, {24'h0, t1});
		apb(1'b1, ADDR_ENABLE, {25'h0, en});
		for (int k = 0; k < ncyc; k++) begin
			#1;
			chk({25'h0, per_led_sink_on}, {25'h0, exp_on(t1, en, k)});
			@(posedge pclk);
		end
		apb(1'b1, ADDR_ENABLE, 32'h0);
		#1;
		chk({25'h0, per_led_sink_on}, 32'h0);
	endtask

	// ==========================================================
	// main sequence
	initial begin
		int ont[4];
		ont = '{2, 6, 8, 12};
		presetn = 1'b0;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h0;
		fails   = 0;
		n_tests = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_law();
		t_regs();
		t_blink(8'h00, 7'h7f, 300);
		for (int c = 0; c < 4; c++) begin
			t_blink({c[1:0], 6'b01_10_11}, 7'h71, 2 * (ont[c] + 18) * TL);
		end
		t_blink(8'b10_11_00_01, 7'h38, 2 * (8 + 18) * TL);
		end_sim();
	end
endmodule // testbench
